// *** atcr_checker.sv ***
// Concurrent checks on the APB answer, interrupt and baud pulse ports of the timer.
// Assumes it is bound into atcr_timer, which has the single pclk domain.
`timescale 1ns/100ps
`default_nettype none
module atcr_checker (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // Ports watched
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    input wire        port_a_rx_clk,
    input wire        port_a_tx_clk,
    input wire        port_b_rx_clk,
    input wire        port_b_tx_clk,
    input wire        irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready held past one cycle");
    property p_rdy_setup; psel && !penable |=> pready && psel && penable; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no answer in the access cycle");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("refusal without pready or with data");
    // A flag clear drops irq at the access edge; a mask write drops it one edge later.
    property p_irq_fall; $fell(irq) |-> $past(pready && pwrite, 1) || $past(pready && pwrite, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
    property p_rxa; port_a_rx_clk |=> !port_a_rx_clk; endproperty
    a_rxa: assert property (p_rxa) else $error("port a receive pulse too long");
    property p_txa; port_a_tx_clk |=> !port_a_tx_clk; endproperty
    a_txa: assert property (p_txa) else $error("port a transmit pulse too long");
    property p_rxb; port_b_rx_clk |=> !port_b_rx_clk; endproperty
    a_rxb: assert property (p_rxb) else $error("port b receive pulse too long");
    property p_txb; port_b_tx_clk |=> !port_b_tx_clk; endproperty
    a_txb: assert property (p_txb) else $error("port b transmit pulse too long");
endmodule
bind atcr_timer atcr_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .prdata,
    .port_a_rx_clk, .port_a_tx_clk, .port_b_rx_clk, .port_b_tx_clk, .irq);
`default_nettype wire

// *** atcr_edge.v ***
// Falling edge detector for a pin input.
// Assumes the pin is synchronous to pclk and sampled only on enable.
`timescale 1ns/100ps
`default_nettype none
module atcr_edge (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Sampling
    input  wire sample_en,
    input  wire pin,
    // Result
    output wire fall
);
    reg prev_reg;
    reg cur_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b1;
            cur_reg  <= 1'b1;
        end else if (sample_en) begin
            prev_reg <= cur_reg;
            cur_reg  <= pin;
        end
    end

    // High in one sample and low in the next one.
    assign fall = sample_en & prev_reg & ~cur_reg;
endmodule
`default_nettype wire

// *** atcr_map.vh ***
// Register map and field positions of the auxiliary timer block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef ATCR_MAP_VH
`define ATCR_MAP_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ATCR_CTRL_ADDR    12'h000
`define ATCR_MODE_ADDR    12'h004
`define ATCR_CNT_ADDR     12'h008
`define ATCR_CAP_ADDR     12'h00c
`define ATCR_PWR_ADDR     12'h010
`define ATCR_MASK_ADDR    12'h014

// ****************************************
// Control register fields
// ****************************************
`define ATCR_CRL_BIT      0
`define ATCR_CT_BIT       1
`define ATCR_RUN_BIT      2
`define ATCR_EXEN_BIT     3
`define ATCR_TX_CLOCK_SELECT_BIT     4
`define ATCR_RCLK_BIT     5
`define ATCR_EXF_BIT      6
`define ATCR_OVF_BIT      7

// ****************************************
// Other fields and reset values
// ****************************************
`define ATCR_DOWN_COUNT_ENABLE_BIT     0
`define ATCR_RCLKB_BIT    0
`define ATCR_TCLKB_BIT    1
`define ATCR_CTRL_RST     8'h00
`define ATCR_CNT_RST      16'h0000
`define ATCR_MASK_RST     2'h0

// ****************************************
// Timing counts
// ****************************************
`define ATCR_TICK_DIV     4'hb

`endif

// *** atcr_port_model.sv ***
// Far side model: the other timer's overflow source and the serial ports' baud clock inputs.
// Assumes the timer's port clocks are single pclk pulses.
`timescale 1ns/100ps
`default_nettype none
module atcr_port_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Timer side
    output var  logic       other_timer_ovf,
    input  wire logic       port_a_rx_clk,
    input  wire logic       port_a_tx_clk,
    input  wire logic       port_b_rx_clk,
    input  wire logic       port_b_tx_clk,
    // Pulses taken by each port
    output var  logic [7:0] n_rxa,
    output var  logic [7:0] n_txa,
    output var  logic [7:0] n_rxb,
    output var  logic [7:0] n_txb
);
    logic [3:0] div_reg;
    // A pulse every 9 pclk, far above the bench's timer wrap rate, shows plainly which source a port takes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 4'h0;
            other_timer_ovf <= 1'b0;
            n_rxa <= 8'h00;
            n_txa <= 8'h00;
            n_rxb <= 8'h00;
            n_txb <= 8'h00;
        end else begin
            div_reg <= (div_reg == 4'h8) ? 4'h0 : div_reg + 4'h1;
            other_timer_ovf <= (div_reg == 4'h8);
            n_rxa <= n_rxa + {7'h00, port_a_rx_clk};
            n_txa <= n_txa + {7'h00, port_a_tx_clk};
            n_rxb <= n_rxb + {7'h00, port_b_rx_clk};
            n_txb <= n_txb + {7'h00, port_b_tx_clk};
        end
    end
endmodule
`default_nettype wire

// *** atcr_timer.v ***
// Auxiliary 16-bit timer/counter with capture, auto-reload and baud clock modes.
// Assumes an APB master on pclk and pins synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
`include "atcr_map.vh"
module atcr_timer (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins
    input  wire        event_count_pin,
    input  wire        trigger_pin,
    // Other timer overflow pulse
    input  wire        other_timer_ovf,
    // Serial port baud clocks
    output reg         port_a_rx_clk,
    output reg         port_a_tx_clk,
    output reg         port_b_rx_clk,
    output reg         port_b_tx_clk,
    // Interrupt
    output reg         irq
);
    // ****************************************
    // Registers
    // ****************************************
    reg  [7:0]  aux_timer_control_reg;
    reg         down_count_enable_reg;
    reg  [1:0]  power_control_reg;
    reg  [1:0]  irq_mask_reg;
    reg  [15:0] count_reg;
    reg  [15:0] capture_reload_reg;
    reg  [3:0]  tick_div_reg;
    reg         tick_reg;

    wire capture_reload_select = aux_timer_control_reg[`ATCR_CRL_BIT];
    wire count_source_select   = aux_timer_control_reg[`ATCR_CT_BIT];
    wire run_bit               = aux_timer_control_reg[`ATCR_RUN_BIT];
    wire ext_trigger_enable    = aux_timer_control_reg[`ATCR_EXEN_BIT];
    wire tx_clock_select       = aux_timer_control_reg[`ATCR_TX_CLOCK_SELECT_BIT];
    wire rx_clock_select       = aux_timer_control_reg[`ATCR_RCLK_BIT];
    wire overflow_flag         = aux_timer_control_reg[`ATCR_OVF_BIT];
    wire ext_trigger_flag      = aux_timer_control_reg[`ATCR_EXF_BIT];
    wire rx_clock_select_port_b = power_control_reg[`ATCR_RCLKB_BIT];
    wire tx_clock_select_port_b = power_control_reg[`ATCR_TCLKB_BIT];

    // ****************************************
    // Machine cycle divider
    // ****************************************
    // With CT clear the count advances once per machine cycle, a twelfth of pclk; with CT set it advances on event pin falls.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_div_reg <= 4'h0;
            tick_reg     <= 1'b0;
        end else if (tick_div_reg == `ATCR_TICK_DIV) begin
            tick_div_reg <= 4'h0;
            tick_reg     <= 1'b1;
        end else begin
            tick_div_reg <= tick_div_reg + 4'h1;
            tick_reg     <= 1'b0;
        end
    end

    // ****************************************
    // Pin edges
    // ****************************************
    wire event_fall;
    wire trigger_fall;

    atcr_edge u_event_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .sample_en (tick_reg),
        .pin       (event_count_pin),
        .fall      (event_fall)
    );

    atcr_edge u_trigger_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .sample_en (tick_reg),
        .pin       (trigger_pin),
        .fall      (trigger_fall)
    );

    // ****************************************
    // Counter core
    // ****************************************
    wire baud_mode = rx_clock_select | tx_clock_select |
                     rx_clock_select_port_b | tx_clock_select_port_b;
    wire reload_mode = baud_mode | ~capture_reload_select;
    wire count_en = run_bit & (count_source_select ? event_fall : tick_reg);
    // Direction follows the trigger pin only in plain reload mode.
    wire count_down = ~baud_mode & ~capture_reload_select &
                      down_count_enable_reg & ~trigger_pin;
    wire use_trigger_dir = ~baud_mode & ~capture_reload_select & down_count_enable_reg;
    wire trig_evt = ext_trigger_enable & trigger_fall & ~use_trigger_dir;
    wire up_wrap   = count_en & ~count_down & (count_reg == 16'hffff);
    wire down_wrap = count_en & count_down & (count_reg == capture_reload_reg);
    wire overflow  = up_wrap | down_wrap;

    reg [15:0] count_next;
    reg [15:0] capture_next;
    always @* begin
        count_next   = count_reg;
        capture_next = capture_reload_reg;
        if (count_en) begin
            if (count_down) begin
                count_next = count_reg - 16'h0001;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
        if (up_wrap && reload_mode) begin
            count_next = capture_reload_reg;
        end
        if (down_wrap) begin
            count_next = 16'hffff;
        end
        if (trig_evt && !baud_mode) begin
            if (capture_reload_select) begin
                capture_next = count_reg;
            end else begin
                count_next = capture_reload_reg;
            end
        end
    end

    // ****************************************
    // APB access
    // ****************************************
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire mapped  = (paddr == `ATCR_CTRL_ADDR) | (paddr == `ATCR_MODE_ADDR) |
                   (paddr == `ATCR_CNT_ADDR) | (paddr == `ATCR_CAP_ADDR) |
                   (paddr == `ATCR_PWR_ADDR) | (paddr == `ATCR_MASK_ADDR);
    wire wr_ctrl = wr & (paddr == `ATCR_CTRL_ADDR);

    // Hardware set wins over a software clear in the same cycle.
    wire set_ovf = overflow & ~baud_mode;
    wire set_exf = trig_evt;
    wire ovf_next = set_ovf | (wr_ctrl ? pwdata[`ATCR_OVF_BIT] : overflow_flag);
    wire exf_next = set_exf | (wr_ctrl ? pwdata[`ATCR_EXF_BIT] : ext_trigger_flag);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_timer_control_reg <= `ATCR_CTRL_RST;
            down_count_enable_reg <= 1'b0;
            power_control_reg     <= 2'h0;
            irq_mask_reg          <= `ATCR_MASK_RST;
            count_reg             <= `ATCR_CNT_RST;
            capture_reload_reg    <= `ATCR_CNT_RST;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h0000_0000;
        end else begin
            count_reg          <= count_next;
            capture_reload_reg <= capture_next;
            aux_timer_control_reg[`ATCR_OVF_BIT] <= ovf_next;
            aux_timer_control_reg[`ATCR_EXF_BIT] <= exf_next;
            if (wr_ctrl) begin
                aux_timer_control_reg[5:0] <= pwdata[5:0];
            end
            if (wr && paddr == `ATCR_MODE_ADDR) begin
                down_count_enable_reg <= pwdata[`ATCR_DOWN_COUNT_ENABLE_BIT];
            end
            if (wr && paddr == `ATCR_PWR_ADDR) begin
                power_control_reg <= pwdata[1:0];
            end
            if (wr && paddr == `ATCR_MASK_ADDR) begin
                irq_mask_reg <= pwdata[1:0];
            end
            // Software writes win over counting so a preset is never lost.
            if (wr && paddr == `ATCR_CNT_ADDR) begin
                count_reg <= pwdata[15:0];
            end
            if (wr && paddr == `ATCR_CAP_ADDR) begin
                capture_reload_reg <= pwdata[15:0];
            end
            // No wait state: answer in the first access cycle.
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ATCR_CTRL_ADDR: prdata <= {24'h000000, aux_timer_control_reg};
                    `ATCR_MODE_ADDR: prdata <= {31'h00000000, down_count_enable_reg};
                    `ATCR_CNT_ADDR:  prdata <= {16'h0000, count_reg};
                    `ATCR_CAP_ADDR:  prdata <= {16'h0000, capture_reload_reg};
                    `ATCR_PWR_ADDR:  prdata <= {30'h00000000, power_control_reg};
                    `ATCR_MASK_ADDR: prdata <= {30'h00000000, irq_mask_reg};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Baud clocks and interrupt
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_rx_clk <= 1'b0;
            port_a_tx_clk <= 1'b0;
            port_b_rx_clk <= 1'b0;
            port_b_tx_clk <= 1'b0;
            irq           <= 1'b0;
        end else begin
            port_a_rx_clk <= rx_clock_select ? overflow : other_timer_ovf;
            port_a_tx_clk <= tx_clock_select ? overflow : other_timer_ovf;
            port_b_rx_clk <= rx_clock_select_port_b ? overflow : other_timer_ovf;
            port_b_tx_clk <= tx_clock_select_port_b ? overflow : other_timer_ovf;
            irq <= (ovf_next & irq_mask_reg[0]) | (exf_next & irq_mask_reg[1]);
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the auxiliary timer, driven over APB with pin stimulus.
// Assumes the timer ticks every 12 pclk and samples pins on those ticks.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        pclk, pready, pslverr, re, ovf_o, rxa, txa, rxb, txb, irq;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev = 1'b1, trig = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic [7:0]  n_rxa, n_txa, n_rxb, n_txb, s0, s1, s2;
    integer      n_mismatch = 0, check_count = 0, i;
    atcr_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .event_count_pin(ev), .trigger_pin(trig), .other_timer_ovf(ovf_o), .port_a_rx_clk(rxa),
        .port_a_tx_clk(txa), .port_b_rx_clk(rxb), .port_b_tx_clk(txb), .irq);
    atcr_port_model u_ports (.pclk, .presetn, .other_timer_ovf(ovf_o), .port_a_rx_clk(rxa),
        .port_a_tx_clk(txa), .port_b_rx_clk(rxb), .port_b_tx_clk(txb), .n_rxa, .n_txa, .n_rxb, .n_txb);
    // ****************************************
    // Tasks
    // ****************************************
    task end_sim;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task ck(input string n, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task xf(input w, input [11:0] a, input [31:0] d);
        integer k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rq = prdata;
        re = pslverr;
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle edge keeps the next call from assigning psel again in this time step.
        @(posedge pclk);
    endtask
    // Each level is held for two ticks so a fall is always seen.
    task fl(input b);
        if (b) trig <= 1'b0; else ev <= 1'b0;
        repeat (26) @(posedge pclk);
        if (b) trig <= 1'b1; else ev <= 1'b1;
        repeat (26) @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xf(0, 12'h000, 0); ck("ctrl_rst", 32'h0, rq);
        xf(0, 12'h014, 0); ck("mask_rst", 32'h0, rq);
        xf(0, 12'h020, 0); ck("unmapped", 32'h1, re);
        xf(1, 12'h000, 32'h02); fl(0); xf(0, 12'h008, 0); ck("cnt_stop", 32'h0, rq);
        xf(1, 12'h000, 32'h06); repeat (3) fl(0); xf(0, 12'h008, 0); ck("cnt_ext", 32'h3, rq);
        xf(1, 12'h014, 32'h1); xf(1, 12'h00c, 32'h1234); xf(1, 12'h008, 32'hfffe); xf(1, 12'h000, 32'h04);
        for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge pclk);
        if (irq !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
        xf(0, 12'h000, 0); ck("ctrl_ovf", 32'h84, rq);
        xf(0, 12'h008, 0); ck("cnt_reload", 32'h123, rq >> 4);
        xf(1, 12'h000, 32'h0); repeat (3) @(posedge pclk); ck("irq_clr", 32'h0, irq);
        // Trigger held low selects down counting; the wrap at the reload value loads ffff.
        trig <= 1'b0;
        xf(1, 12'h004, 32'h1); xf(1, 12'h00c, 32'h0010); xf(1, 12'h008, 32'h0012); xf(1, 12'h000, 32'h04);
        repeat (60) @(posedge pclk);
        xf(0, 12'h000, 0); ck("ctrl_down", 32'h84, rq);
        xf(0, 12'h008, 0); ck("cnt_down", 32'hff, rq >> 8);
        xf(1, 12'h000, 32'h0); xf(1, 12'h004, 32'h0);
        trig <= 1'b1;
        repeat (3) @(posedge pclk);
        xf(1, 12'h014, 32'h2); xf(1, 12'h008, 32'h0100); xf(1, 12'h000, 32'h0d); fl(1);
        xf(0, 12'h00c, 0); ck("cap", 32'h010, rq >> 4);
        ck("irq_ext", 32'h1, irq);
        xf(0, 12'h000, 0); ck("ctrl_cap", 32'h4d, rq);
        xf(1, 12'h00c, 32'h2340); xf(1, 12'h000, 32'h0c); fl(1);
        xf(0, 12'h008, 0); ck("cnt_trig", 32'h234, rq >> 4);
        xf(1, 12'h000, 32'h05); fl(1); xf(0, 12'h000, 0); ck("ctrl_noext", 32'h05, rq);
        ck("irq_noext", 32'h0, irq);
        xf(1, 12'h00c, 32'hfff0); xf(1, 12'h008, 32'hfffe); xf(1, 12'h010, 32'h3); xf(1, 12'h000, 32'h2d);
        s0 = n_rxa;
        s1 = n_txa;
        s2 = n_rxb;
        repeat (220) @(posedge pclk);
        ck("rxa_own", 32'h1, 8'(n_rxa - s0) > 8'h00 && 8'(n_rxa - s0) < 8'h04);
        ck("txa_other", 32'h1, 8'(n_txa - s1) > 8'h08);
        ck("rxb_own", 32'h1, 8'(n_rxb - s2) > 8'h00 && 8'(n_rxb - s2) < 8'h04);
        xf(0, 12'h000, 0); ck("ctrl_baud", 32'h2d, rq);
        xf(0, 12'h008, 0); ck("cnt_baud", 32'hfff, rq >> 4);
        fl(1); xf(0, 12'h000, 0); ck("ctrl_baud_ext", 32'h6d, rq);
        end_sim;
    end
endmodule
`default_nettype wire
